// ### src/hbr_defines.svh
/*
 * constants of the host bus register bank: offsets, field positions,
 * reset values and eeprom word numbers.
 * assumes it is included by bare name after the package is known.
 */
`ifndef HBR_DEFINES_SVH
`define HBR_DEFINES_SVH

// byte offsets inside a bank
`define HBR_OFF_BASE 4'h0
`define HBR_OFF_WMARK 4'h4
`define HBR_OFF_BUSERR 4'h6
`define HBR_OFF_BURST 4'h8
`define HBR_OFF_DWORD_C 4'hC
`define HBR_OFF_BANKPTR 4'hE
`define HBR_OFF_MAC_LOW 4'h0
`define HBR_OFF_MAC_MID 4'h2
`define HBR_OFF_MAC_HIGH 4'h4

// bank numbers
`define HBR_BANK_CFG 6'h00
`define HBR_BANK_MAC 6'h02

// field positions
`define HBR_BANK_MSB 5
`define HBR_BASE_UP_MSB 15
`define HBR_BASE_UP_LSB 8
`define HBR_BASE_LO_MSB 7
`define HBR_BASE_LO_LSB 5
`define HBR_WMARK_BIT 12
`define HBR_ERR_FLAG_BIT 15
`define HBR_ERR_VAL_MSB 14
`define HBR_ERR_VAL_LSB 11
`define HBR_MIXED_BIT 10
`define HBR_BURST_MSB 14
`define HBR_BURST_LSB 12

// reset values
`define HBR_BANK_RST 6'h00
`define HBR_BASE_UP_RST 8'h03
`define HBR_BASE_LO_RST 3'h0
`define HBR_WMARK_RST 1'b0
`define HBR_BURST_RST 3'h0
`define HBR_MAC_RST 16'h0000

// eeprom word numbers
`define HBR_EE_BASE_WORD 8'h00
`define HBR_EE_MAC_LAST 8'h03

// cycles the synchronised strap settles before it is trusted
`define HBR_STRAP_SETTLE 2'd2

`endif

// ### src/hbr_pkg.sv
/*
 * types of the host bus register bank.
 * assumes nothing of its surroundings.
 */
package hbr_pkg;

	typedef enum logic [2:0] {
		HBR_LD_IDLE = 3'b001,
		HBR_LD_ISSUE = 3'b010,
		HBR_LD_DONE = 3'b100
	} hbr_ld_state_t;

	typedef struct packed {
		hbr_ld_state_t state;
		logic [7:0] word;
		logic req;
		logic wr;
		logic [1:0] wr_idx;
		logic [15:0] wr_data;
		logic busy;
	} hbr_ld_regs_t;

	typedef struct packed {
		logic strap_meta;
		logic strap_sync;
		logic [1:0] settle;
		logic started;
		logic [5:0] bank;
		logic [7:0] base_up;
		logic [2:0] base_lo;
		logic wmark;
		logic err_flag;
		logic [3:0] err_val;
		logic mixed;
		logic [2:0] burst;
		logic [2:0][15:0] mac;
		logic [31:0] rdata;
		logic ack;
	} hbr_regs_t;

endpackage

// ### src/hbr_eeprom_loader.sv
/*
 * walks eeprom words 0 to 3 once after reset, only when the strap is high,
 * and hands each word to the register bank as a one-cycle write.
 * assumes a serial eeprom engine on the same clock that answers a held
 * request with a one-cycle ack carrying the word.
 */
`timescale 1ns/1ns
`default_nettype none
`include "hbr_defines.svh"

module hbr_eeprom_loader
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// control from the bank
	input wire logic start_i,
	input wire logic strap_i,
	// eeprom engine
	output logic ee_req_o,
	output logic [7:0] ee_word_o,
	input wire logic ee_ack_i,
	input wire logic [15:0] ee_data_i,
	// write toward the bank
	output logic ld_wr_o,
	output logic [1:0] ld_idx_o,
	output logic [15:0] ld_data_o,
	output logic ld_busy_o
);
	import hbr_pkg::*;

	hbr_ld_regs_t q;
	hbr_ld_regs_t nxt_q;

	////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_q = q;
		nxt_q.wr = 1'b0;
		case (q.state)
			HBR_LD_IDLE:
			begin
				// no eeprom fitted: nothing is loaded at all
				if (start_i && strap_i)
				begin
					nxt_q.state = HBR_LD_ISSUE;
					nxt_q.word = `HBR_EE_BASE_WORD;
					nxt_q.req = 1'b1;
					nxt_q.busy = 1'b1;
				end
				else if (start_i)
				begin
					nxt_q.state = HBR_LD_DONE;
				end
			end
			HBR_LD_ISSUE:
			begin
				if (ee_ack_i)
				begin
					nxt_q.wr = 1'b1;
					nxt_q.wr_idx = q.word[1:0];
					nxt_q.wr_data = ee_data_i;
					// consecutive words 1..3 follow the base word
					if (q.word == `HBR_EE_MAC_LAST)
					begin
						// busy drops in done, once the last word has landed
						nxt_q.state = HBR_LD_DONE;
						nxt_q.req = 1'b0;
					end
					else
					begin
						nxt_q.word = q.word + 8'h01;
					end
				end
			end
			HBR_LD_DONE:
			begin
				nxt_q.busy = 1'b0;
			end
			default:
			begin
				nxt_q.state = HBR_LD_DONE;
				nxt_q.req = 1'b0;
				nxt_q.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			q.state <= HBR_LD_IDLE;
			q.word <= 8'h00;
			q.req <= 1'b0;
			q.wr <= 1'b0;
			q.wr_idx <= 2'h0;
			q.wr_data <= 16'h0000;
			q.busy <= 1'b0;
		end
		else
		begin
			q <= nxt_q;
		end
	end

	assign ee_req_o = q.req;
	assign ee_word_o = q.word;
	assign ld_wr_o = q.wr;
	assign ld_idx_o = q.wr_idx;
	assign ld_data_o = q.wr_data;
	assign ld_busy_o = q.busy;

endmodule

`default_nettype wire

// ### src/hbr_register_bank.sv
/*
 * host bus register bank: base address decode, bank pointer, bank 0
 * configuration and error registers, bank 2 host station address, and
 * eeprom load of base and station address after reset.
 * assumes a host bus front end on sys_clk_i that presents one access per
 * one-cycle host_req_i with a 32-bit aligned word address and byte enables.
 */
// Notes on behaviour
// - write-one-to-clear bits clear on a one, keep on a zero
// - six-bit bank pointer, reset zero, picks one of 64 banks
// - bank pointer decoded at offset 0x0E in every bank
// - pointer reachable as dword at 0xC, word or byte at 0xE
// - dword write at 0xC only changes the pointer at 0xE
// - device selected when address 15:8 and 7:5 match base address
// - strap high: base address loaded from eeprom word 0 after reset
// - strap low: base address resets to 0x0300, low bits read zero
// - host writes change base register only, never the eeprom
// - watermark bit 12: zero selects 3 KB, one selects 2 KB
// - illegal byte enables set flag 15, record enables in 14-11
// - recorded enables valid only while flag set; flag is write-one-clear
// - simultaneous sync and async transfers set bit 10, write-one-clear
// - burst field 14-12: 000 single, 011 four, 101 eight, 111 sixteen
// - bank 1 holds nothing but the bank pointer
// - station address loaded from eeprom words 1 through 3 after reset
// - low, middle, high words hold bytes 2-1, 4-3, 6-5
// - host writes to station address never touch the eeprom
// - without eeprom the station address is left for software
`timescale 1ns/1ns
`default_nettype none
`include "hbr_defines.svh"

module hbr_register_bank
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// strap pin
	input wire logic eeprom_enable_strap_i,
	// host access
	input wire logic host_req_i,
	input wire logic host_wr_i,
	input wire logic [15:0] host_addr_i,
	input wire logic [3:0] host_be_i,
	input wire logic [31:0] host_wdata_i,
	input wire logic host_mixed_xfer_i,
	output logic host_ack_o,
	output logic [31:0] host_rdata_o,
	// eeprom word engine
	output logic ee_req_o,
	output logic [7:0] ee_word_o,
	input wire logic ee_ack_i,
	input wire logic [15:0] ee_data_i,
	// configuration toward the rest of the device
	output logic [5:0] bank_pointer_o,
	output logic rx_wmark_2k_o,
	output logic [2:0] burst_size_o,
	output logic [47:0] host_station_addr_o,
	output logic eeprom_load_busy_o
);
	import hbr_pkg::*;

	hbr_regs_t q;
	hbr_regs_t nxt_q;

	logic ld_wr;
	logic [1:0] ld_idx;
	logic [15:0] ld_data;
	logic ld_start;
	logic selected;
	logic be_legal;
	logic [15:0] rd_lo;
	logic [15:0] rd_hi;

	////////////////////////////////////////////////////////////////////
	// eeprom load sequencer

	assign ld_start = (q.settle == `HBR_STRAP_SETTLE) && !q.started;

	hbr_eeprom_loader u_loader
	(
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(ld_start),
		.strap_i(q.strap_sync),
		.ee_req_o(ee_req_o),
		.ee_word_o(ee_word_o),
		.ee_ack_i(ee_ack_i),
		.ee_data_i(ee_data_i),
		.ld_wr_o(ld_wr),
		.ld_idx_o(ld_idx),
		.ld_data_o(ld_data),
		.ld_busy_o(eeprom_load_busy_o)
	);

	////////////////////////////////////////////////////////////////////
	// decode

	assign selected = host_req_i
		&& (host_addr_i[15:8] == q.base_up)
		&& (host_addr_i[7:5] == q.base_lo);

	// byte, aligned word and dword are the only legal shapes
	always_comb
	begin
		case (host_be_i)
			4'b0001, 4'b0010, 4'b0100, 4'b1000,
			4'b0011, 4'b1100, 4'b1111: be_legal = 1'b1;
			default: be_legal = 1'b0;
		endcase
	end

	function automatic logic [15:0] read_half(input hbr_regs_t r,
		input logic [3:0] off);
		logic [15:0] v;
		v = 16'h0000;
		if (off == `HBR_OFF_BANKPTR)
		begin
			v[`HBR_BANK_MSB:0] = r.bank;
		end
		else if (r.bank == `HBR_BANK_CFG)
		begin
			case (off)
				`HBR_OFF_BASE:
				begin
					v[`HBR_BASE_UP_MSB:`HBR_BASE_UP_LSB] = r.base_up;
					v[`HBR_BASE_LO_MSB:`HBR_BASE_LO_LSB] = r.base_lo;
				end
				`HBR_OFF_WMARK: v[`HBR_WMARK_BIT] = r.wmark;
				`HBR_OFF_BUSERR:
				begin
					v[`HBR_ERR_FLAG_BIT] = r.err_flag;
					v[`HBR_ERR_VAL_MSB:`HBR_ERR_VAL_LSB] = r.err_val;
					v[`HBR_MIXED_BIT] = r.mixed;
				end
				`HBR_OFF_BURST: v[`HBR_BURST_MSB:`HBR_BURST_LSB] = r.burst;
				default: v = 16'h0000;
			endcase
		end
		else if (r.bank == `HBR_BANK_MAC)
		begin
			case (off)
				`HBR_OFF_MAC_LOW: v = r.mac[0];
				`HBR_OFF_MAC_MID: v = r.mac[1];
				`HBR_OFF_MAC_HIGH: v = r.mac[2];
				default: v = 16'h0000;
			endcase
		end
		return v;
	endfunction

	assign rd_lo = read_half(q, {host_addr_i[3:2], 2'b00});
	assign rd_hi = read_half(q, {host_addr_i[3:2], 2'b10});

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		logic [3:0] off;
		logic [1:0] m;
		logic [15:0] d;
		off = 4'h0;
		m = 2'b00;
		d = 16'h0000;
		nxt_q = q;
		nxt_q.ack = 1'b0;

		// strap is a pin: two flops before anything looks at it
		nxt_q.strap_meta = eeprom_enable_strap_i;
		nxt_q.strap_sync = q.strap_meta;
		if (q.settle != `HBR_STRAP_SETTLE)
		begin
			nxt_q.settle = q.settle + 2'd1;
		end
		if (ld_start)
		begin
			nxt_q.started = 1'b1;
		end

		if (selected)
		begin
			nxt_q.ack = 1'b1;
			nxt_q.rdata = 32'h0000_0000;
			if (be_legal && !host_wr_i)
			begin
				nxt_q.rdata = {rd_hi, rd_lo};
			end
		end

		// host writes land in on-chip state only; nothing goes to eeprom
		if (selected && be_legal && host_wr_i)
		begin
			for (int h = 0; h < 2; h++)
			begin
				off = {host_addr_i[3:2], h[0], 1'b0};
				m = host_be_i[2 * h +: 2];
				d = host_wdata_i[16 * h +: 16];
				// offset 0xC of a dword write falls through here
				if (off == `HBR_OFF_BANKPTR)
				begin
					if (m[0])
					begin
						nxt_q.bank = d[`HBR_BANK_MSB:0];
					end
				end
				else if (q.bank == `HBR_BANK_CFG)
				begin
					case (off)
						`HBR_OFF_BASE:
						begin
							if (m[1])
							begin
								nxt_q.base_up = d[15:8];
							end
							if (m[0])
							begin
								nxt_q.base_lo = d[7:5];
							end
						end
						`HBR_OFF_WMARK:
						begin
							if (m[1])
							begin
								nxt_q.wmark = d[`HBR_WMARK_BIT];
							end
						end
						`HBR_OFF_BUSERR:
						begin
							if (m[1] && d[`HBR_ERR_FLAG_BIT])
							begin
								nxt_q.err_flag = 1'b0;
							end
							if (m[1] && d[`HBR_MIXED_BIT])
							begin
								nxt_q.mixed = 1'b0;
							end
						end
						`HBR_OFF_BURST:
						begin
							if (m[1])
							begin
								nxt_q.burst = d[14:12];
							end
						end
						default:
						begin
							nxt_q.bank = nxt_q.bank;
						end
					endcase
				end
				else if (q.bank == `HBR_BANK_MAC)
				begin
					for (int k = 0; k < 3; k++)
					begin
						if (off == 4'(2 * k))
						begin
							if (m[0])
							begin
								nxt_q.mac[k][7:0] = d[7:0];
							end
							if (m[1])
							begin
								nxt_q.mac[k][15:8] = d[15:8];
							end
						end
					end
				end
				// any other bank, bank 1 included, has no storage
			end
		end

		// error sets come after clears so a same-cycle event wins
		if (selected && !be_legal)
		begin
			nxt_q.err_flag = 1'b1;
			if (!q.err_flag)
			begin
				nxt_q.err_val = host_be_i;
			end
		end
		if (host_mixed_xfer_i)
		begin
			nxt_q.mixed = 1'b1;
		end

		// eeprom load overrides a host write landing in the same cycle
		if (ld_wr)
		begin
			if (ld_idx == 2'd0)
			begin
				nxt_q.base_up = ld_data[15:8];
				nxt_q.base_lo = ld_data[7:5];
			end
			else
			begin
				nxt_q.mac[ld_idx - 2'd1] = ld_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			q.strap_meta <= 1'b0;
			q.strap_sync <= 1'b0;
			q.settle <= 2'd0;
			q.started <= 1'b0;
			q.bank <= `HBR_BANK_RST;
			q.base_up <= `HBR_BASE_UP_RST;
			q.base_lo <= `HBR_BASE_LO_RST;
			q.wmark <= `HBR_WMARK_RST;
			q.err_flag <= 1'b0;
			q.err_val <= 4'h0;
			q.mixed <= 1'b0;
			q.burst <= `HBR_BURST_RST;
			q.mac <= {3{`HBR_MAC_RST}};
			q.rdata <= 32'h0000_0000;
			q.ack <= 1'b0;
		end
		else
		begin
			q <= nxt_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign host_ack_o = q.ack;
	assign host_rdata_o = q.rdata;
	assign bank_pointer_o = q.bank;
	assign rx_wmark_2k_o = q.wmark;
	assign burst_size_o = q.burst;
	assign host_station_addr_o = {q.mac[2], q.mac[1], q.mac[0]};

endmodule

`default_nettype wire

// ### sim/hbr_register_bank_properties.sv
/* port-level properties of the host bus register bank.
   assumes the bank's single clock and async active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module hbr_register_bank_properties
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// host access
	input wire logic host_req_i,
	input wire logic host_wr_i,
	input wire logic [15:0] host_addr_i,
	input wire logic [3:0] host_be_i,
	input wire logic [31:0] host_wdata_i,
	input wire logic host_ack_o,
	input wire logic [31:0] host_rdata_o,
	// eeprom and configuration
	input wire logic ee_req_o,
	input wire logic [7:0] ee_word_o,
	input wire logic ee_ack_i,
	input wire logic [15:0] ee_data_i,
	input wire logic [5:0] bank_pointer_o,
	input wire logic rx_wmark_2k_o,
	input wire logic [2:0] burst_size_o,
	input wire logic [47:0] host_station_addr_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	wire logic bad_be = !(host_be_i inside {4'h1, 4'h2, 4'h4, 4'h8,
		4'h3, 4'hC, 4'hF});
	////////////////////////////////////////
	sequence s_ptr_wr;
		host_req_i && host_wr_i && !bad_be && host_be_i[2] &&
		host_addr_i[3:2] == 2'b11 ##1 host_ack_o;
	endsequence
	sequence s_ee_low;
		ee_req_o && ee_ack_i && ee_word_o == 8'h01;
	endsequence
	property p_ack_cause;
		host_ack_o |-> $past(host_req_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	property p_ptr_load;
		s_ptr_wr |-> bank_pointer_o == $past(host_wdata_i[21:16]);
	endproperty
	a_ptr_load: assert property (p_ptr_load)
		else $error("pointer not loaded from lane 2");
	property p_ptr_hold;
		$changed(bank_pointer_o) |-> host_ack_o &&
			$past(host_wr_i && host_addr_i[3:2] == 2'b11);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold)
		else $error("pointer changed without write");
	property p_wmark;
		$changed(rx_wmark_2k_o) |-> host_ack_o &&
			$past(host_wr_i && host_be_i[1] && host_addr_i[3:2] == 2'b01);
	endproperty
	a_wmark: assert property (p_wmark)
		else $error("watermark changed without write");
	property p_burst;
		$changed(burst_size_o) |-> host_ack_o &&
			$past(host_wr_i && host_be_i[1] && host_addr_i[3:2] == 2'b10);
	endproperty
	a_burst: assert property (p_burst)
		else $error("burst changed without write");
	property p_bad_be;
		host_req_i && bad_be ##1 host_ack_o |-> host_rdata_o == 32'h0;
	endproperty
	a_bad_be: assert property (p_bad_be)
		else $error("illegal enables returned data");
	property p_ee_first;
		$rose(ee_req_o) |-> ee_word_o == 8'h00;
	endproperty
	a_ee_first: assert property (p_ee_first)
		else $error("load did not start at word 0");
	property p_ee_hold;
		ee_req_o && !ee_ack_i |=> ee_req_o && $stable(ee_word_o);
	endproperty
	a_ee_hold: assert property (p_ee_hold)
		else $error("eeprom request dropped early");
	property p_ee_step;
		ee_req_o && ee_ack_i && ee_word_o < 8'h03 |=>
			ee_word_o == $past(ee_word_o) + 8'h01;
	endproperty
	a_ee_step: assert property (p_ee_step)
		else $error("eeprom words out of order");
	property p_ee_low;
		s_ee_low |-> ##3 host_station_addr_o[15:0] == $past(ee_data_i, 3);
	endproperty
	a_ee_low: assert property (p_ee_low)
		else $error("low station word not loaded");
endmodule
bind hbr_register_bank hbr_register_bank_properties
	u_hbr_register_bank_properties (.sys_clk_i, .sys_rst_i, .host_req_i,
	.host_wr_i, .host_addr_i, .host_be_i, .host_wdata_i, .host_ack_o,
	.host_rdata_o, .ee_req_o, .ee_word_o, .ee_ack_i, .ee_data_i,
	.bank_pointer_o, .rx_wmark_2k_o, .burst_size_o, .host_station_addr_o);
`default_nettype wire

// ### sim/hbr_ee_model.sv
/* eeprom word engine model: answers word n after n idle cycles.
   assumes the bank's held request and word number on one clock. */
`timescale 1ns/1ns
`default_nettype none
module hbr_ee_model
(
	// clock
	input wire logic sys_clk_i,
	// word request
	input wire logic ee_req_i,
	input wire logic [7:0] ee_word_i,
	// answer
	output logic ee_ack_o,
	output logic [15:0] ee_data_o
);
	logic [15:0] mem [4] = '{16'h127F, 16'h89AB, 16'h4567, 16'h0123};
	logic [1:0] wait_cnt = 2'd0;
	initial ee_ack_o = 1'b0;
	initial ee_data_o = 16'h0000;
	// data toggles while idle so a stale word never passes as fresh
	always @(posedge sys_clk_i)
	begin
		ee_ack_o <= 1'b0;
		ee_data_o <= ~ee_data_o;
		wait_cnt <= 2'd0;
		if (ee_req_i && !ee_ack_o)
		begin
			wait_cnt <= wait_cnt + 2'd1;
			if (wait_cnt == ee_word_i[1:0])
			begin
				ee_ack_o <= 1'b1;
				ee_data_o <= mem[ee_word_i[1:0]];
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/hbr_register_bank_test.sv
/* self-checking bench of the host bus register bank.
   assumes the eeprom model as the only far-side party. */
`timescale 1ns/1ns
`default_nettype none
module hbr_register_bank_test;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic eeprom_enable_strap_i = 1'b0;
	logic host_req_i = 1'b0;
	logic host_wr_i = 1'b0;
	logic host_mixed_xfer_i = 1'b0;
	logic [15:0] host_addr_i = 16'h0000;
	logic [3:0] host_be_i = 4'h0;
	logic [31:0] host_wdata_i = 32'h0000_0000;
	logic host_ack_o, ee_req_o, ee_ack_i, rx_wmark_2k_o, eeprom_load_busy_o;
	logic [31:0] host_rdata_o, got_rd;
	logic [7:0] ee_word_o;
	logic [15:0] ee_data_i;
	logic [5:0] bank_pointer_o;
	logic [2:0] burst_size_o;
	logic [47:0] host_station_addr_o;
	logic [15:0] base = 16'h0300;
	logic got_ack;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	hbr_register_bank u_hbr_register_bank (.sys_clk_i, .sys_rst_i,
		.eeprom_enable_strap_i, .host_req_i, .host_wr_i, .host_addr_i,
		.host_be_i, .host_wdata_i, .host_mixed_xfer_i, .host_ack_o,
		.host_rdata_o, .ee_req_o, .ee_word_o, .ee_ack_i, .ee_data_i,
		.bank_pointer_o, .rx_wmark_2k_o, .burst_size_o,
		.host_station_addr_o, .eeprom_load_busy_o);
	hbr_ee_model u_hbr_ee_model (.sys_clk_i, .ee_req_i(ee_req_o),
		.ee_word_i(ee_word_o), .ee_ack_o(ee_ack_i), .ee_data_o(ee_data_i));
	always #5 sys_clk_i = ~sys_clk_i;
	////////////////////////////////////////
	task chk(input logic [47:0] g, input logic [47:0] e);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one request cycle, then one spare cycle so req never toggles twice
	task acc(input logic w, input logic [3:0] o, input logic [3:0] b,
		input logic [31:0] d);
		host_wr_i = w;
		host_addr_i = base | {12'h000, o};
		host_be_i = b;
		host_wdata_i = d;
		host_req_i = 1'b1;
		@(negedge sys_clk_i);
		host_req_i = 1'b0;
		got_ack = host_ack_o;
		got_rd = host_rdata_o;
		@(negedge sys_clk_i);
	endtask
	task rd_chk(input logic [3:0] o, input logic [3:0] b,
		input logic [31:0] e);
		acc(1'b0, o, b, 32'h0000_0000);
		chk(got_ack, 1'b1);
		chk(got_rd, e);
	endtask
	task rst(input logic s);
		eeprom_enable_strap_i = s;
		sys_rst_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		repeat (5) @(negedge sys_clk_i);
	endtask
	////////////////////////////////////////
	task t_defaults;
		rst(1'b0);
		chk(host_station_addr_o, 48'h0);
		chk({rx_wmark_2k_o, burst_size_o, bank_pointer_o}, 0);
		rd_chk(4'h0, 4'h3, 32'h0000_0300);
	endtask
	task t_bank;
		acc(1'b1, 4'hC, 4'hF, 32'hFFFF_FFFF);
		chk(bank_pointer_o, 6'h3F);
		rd_chk(4'hC, 4'hF, 32'h003F_0000);
		acc(1'b1, 4'hC, 4'hC, 32'h0001_0000);
		rd_chk(4'h0, 4'h3, 32'h0000_0000);
		acc(1'b1, 4'hC, 4'h4, 32'h0000_0000);
		rd_chk(4'h0, 4'h3, 32'h0000_0300);
	endtask
	task t_cfg;
		logic [2:0] codes [4] = '{3'b011, 3'b101, 3'b111, 3'b000};
		rd_chk(4'h4, 4'h3, 32'h0000_0000);
		acc(1'b1, 4'h4, 4'h3, got_rd | 32'h0000_F000);
		chk(rx_wmark_2k_o, 1'b1);
		rd_chk(4'h4, 4'h3, 32'h0000_1000);
		foreach (codes[i])
		begin
			acc(1'b1, 4'h8, 4'h3, {17'h0, codes[i], 12'h000});
			chk(burst_size_o, codes[i]);
		end
	endtask
	task t_err;
		acc(1'b0, 4'h0, 4'h5, 32'h0000_0000);
		chk({got_ack, got_rd}, 33'h1_0000_0000);
		acc(1'b1, 4'h0, 4'h6, 32'hFFFF_FFFF);
		rd_chk(4'h4, 4'hC, 32'hA800_1000);
		rd_chk(4'h0, 4'h3, 32'h0000_0300);
		host_mixed_xfer_i = 1'b1;
		@(negedge sys_clk_i);
		host_mixed_xfer_i = 1'b0;
		rd_chk(4'h4, 4'hC, 32'hAC00_1000);
		acc(1'b1, 4'h4, 4'hC, 32'h0000_0000);
		rd_chk(4'h4, 4'hC, 32'hAC00_1000);
		acc(1'b1, 4'h4, 4'hC, 32'h8400_0000);
		acc(1'b0, 4'h4, 4'hC, 32'h0000_0000);
		chk(got_rd & 32'h8400_0000, 0);
	endtask
	task t_base;
		acc(1'b1, 4'h0, 4'h3, 32'h0000_0A5F);
		base = 16'h0300;
		acc(1'b0, 4'h0, 4'h3, 32'h0000_0000);
		chk(got_ack, 1'b0);
		base = 16'h0A60;
		acc(1'b0, 4'h0, 4'h3, 32'h0000_0000);
		chk(got_ack, 1'b0);
		base = 16'h0A40;
		rd_chk(4'h0, 4'h3, 32'h0000_0A40);
		chk(ee_req_o, 1'b0);
	endtask
	task t_load;
		rst(1'b1);
		chk(eeprom_load_busy_o, 1'b1);
		for (int i = 0; i < 40 && eeprom_load_busy_o !== 1'b0; i++)
			@(negedge sys_clk_i);
		chk(eeprom_load_busy_o, 1'b0);
		chk(host_station_addr_o, 48'h0123_4567_89AB);
		base = 16'h1260;
		rd_chk(4'h0, 4'h3, 32'h0000_1260);
		acc(1'b1, 4'hC, 4'h4, 32'h0002_0000);
		acc(1'b1, 4'h0, 4'h3, 32'h0000_BEEF);
		chk({ee_req_o, host_station_addr_o}, 49'h0_0123_4567_BEEF);
	endtask
	////////////////////////////////////////
	task results;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			results;
		end
	end
	initial
	begin
		t_defaults;
		t_bank;
		t_cfg;
		t_err;
		t_base;
		t_load;
		results;
	end
endmodule
`default_nettype wire
